// file: power_mgmt_event_status.sv
// Power management event status, enables, suspend control and free-running timer.
`timescale 1ns/100ps
`default_nettype none
`include "pm_event_consts.svh"

module power_mgmt_event_status
    import pm_event_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = `PM_DEBOUNCE_MS * 1000 * `PM_CLK_MHZ,
    parameter int unsigned OVERRIDE_CYCLES = `PM_OVERRIDE_S * `PM_CLK_HZ
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [15:0] pm_base,
    input  wire logic        pm_io_enable,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [31:0] io_wdata,
    output logic      [31:0] io_rdata,
    output logic             io_claim,
    input  wire logic        power_button_n,
    input  wire logic [3:0]  pci_request_n,
    input  wire logic        pc_pci_hold_n,
    input  wire logic        lid_in,
    input  wire logic        osc_running,
    input  wire logic        alarm_irq,
    input  wire logic        thermal_event,
    input  wire logic        general_input_event,
    input  wire logic        usb_activity_event,
    input  wire logic        override_enable,
    input  wire logic        lid_polarity,
    input  wire logic        lid_event_enable,
    input  wire logic        firmware_release_bit,
    input  wire logic        firmware_event_enable,
    input  wire logic        firmware_event_clear,
    output logic             firmware_event_flag,
    output logic             sci_out,
    output logic             mgmt_interrupt_n,
    output logic             wake_to_on,
    output logic             power_off,
    output logic             suspend_start,
    output logic      [2:0]  suspend_kind,
    output logic             burst_reload_event
);

    localparam logic [26:0] TMR_STEP = 27'(`PM_TMR_HZ);
    localparam logic [26:0] TMR_WRAP = 27'(`PM_CLK_HZ);
    localparam logic [28:0] DEB_CNT  = 29'(DEBOUNCE_CYCLES);
    localparam logic [28:0] OVR_CNT  = 29'(OVERRIDE_CYCLES);

    function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                                 input logic [15:0] ofs);
        hit = (a == ((base & `PM_BASE_MASK) + ofs));
    endfunction

    // ====================
    // Pin synchronisers
    // =========================================================================
    logic [7:0] pin_s1_r;
    logic [7:0] pin_s2_r;
    logic [7:0] pin_raw;
    logic       button_low;
    logic       bus_req;
    logic       lid_level;
    logic       osc_ok;

    assign pin_raw = {power_button_n, pci_request_n, pc_pci_hold_n, lid_in, osc_running};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_s1_r <= 8'hff;
            pin_s2_r <= 8'hff;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    assign button_low = ~pin_s2_r[7];
    assign bus_req    = ~(&pin_s2_r[6:2]);
    assign lid_level  = pin_s2_r[1] ^ ~lid_polarity;
    assign osc_ok     = pin_s2_r[0];

    // ====================
    // Register decode
    // =========================================================================
    logic sel_status;
    logic sel_resume_en;
    logic sel_control;
    logic sel_timer;
    logic sel_gp;
    logic any_sel;
    logic wr_status;
    logic wr_gp;
    logic wr_control;

    always_comb begin
        sel_status    = pm_io_enable && hit(io_addr, pm_base, `PM_OFS_STATUS);
        sel_resume_en = pm_io_enable && hit(io_addr, pm_base, `PM_OFS_RESUME_EN);
        sel_control   = pm_io_enable && hit(io_addr, pm_base, `PM_OFS_CONTROL);
        sel_timer     = pm_io_enable && hit(io_addr, pm_base, `PM_OFS_TIMER);
        sel_gp        = pm_io_enable && hit(io_addr, pm_base, `PM_OFS_GP_STATUS);
        any_sel       = sel_status | sel_resume_en | sel_control | sel_timer | sel_gp;
        io_claim      = any_sel & (io_wr | io_rd);
        wr_status     = io_wr & sel_status;
        wr_gp         = io_wr & sel_gp;
        wr_control    = io_wr & sel_control;
    end

    // ====================
    // Timer
    // =========================================================================
    logic [26:0] tmr_acc_r;
    logic [26:0] tmr_acc_nxt;
    logic [23:0] timer_count_r;
    logic [23:0] timer_count_nxt;
    logic        tmr_tick;
    logic        tmr_toggle;

    always_comb begin
        tmr_acc_nxt     = tmr_acc_r;
        timer_count_nxt = timer_count_r;
        tmr_tick        = 1'b0;
        if (osc_ok) begin
            if (tmr_acc_r + TMR_STEP >= TMR_WRAP) begin
                tmr_acc_nxt = tmr_acc_r + TMR_STEP - TMR_WRAP;
                tmr_tick    = 1'b1;
            end else begin
                tmr_acc_nxt = tmr_acc_r + TMR_STEP;
            end
        end
        if (tmr_tick) begin
            timer_count_nxt = timer_count_r + 24'h000001;
        end
        tmr_toggle = timer_count_nxt[`PM_TMR_MSB] != timer_count_r[`PM_TMR_MSB];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tmr_acc_r     <= 27'h0000000;
            timer_count_r <= 24'h000000;
        end else begin
            tmr_acc_r     <= tmr_acc_nxt;
            timer_count_r <= timer_count_nxt;
        end
    end

    // ====================
    // Power button debounce and override
    // =========================================================================
    button_state_e btn_state_r;
    button_state_e btn_state_nxt;
    logic [28:0]   btn_cnt_r;
    logic [28:0]   btn_cnt_nxt;
    logic          btn_set;
    logic          btn_override_hit;

    always_comb begin
        btn_state_nxt    = btn_state_r;
        btn_cnt_nxt      = btn_cnt_r + 29'h0000001;
        btn_set          = 1'b0;
        btn_override_hit = 1'b0;
        unique case (btn_state_r)
            btn_idle: begin
                btn_cnt_nxt = 29'h0000000;
                if (button_low) begin
                    btn_state_nxt = btn_debounce;
                end
            end
            btn_debounce: begin
                if (!button_low) begin
                    btn_state_nxt = btn_idle;
                end else if (btn_cnt_r >= DEB_CNT - 29'h0000001) begin
                    btn_set       = 1'b1;
                    btn_state_nxt = btn_pressed;
                end
            end
            btn_pressed: begin
                if (!button_low) begin
                    btn_state_nxt = btn_idle;
                end else if (btn_cnt_r >= OVR_CNT - 29'h0000001) begin
                    btn_override_hit = override_enable;
                    btn_state_nxt    = btn_override;
                end
            end
            btn_override: begin
                btn_cnt_nxt = btn_cnt_r;
                if (!button_low) begin
                    btn_state_nxt = btn_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            btn_state_r <= btn_idle;
            btn_cnt_r   <= 29'h0000000;
        end else begin
            btn_state_r <= btn_state_nxt;
            btn_cnt_r   <= btn_cnt_nxt;
        end
    end

    // ====================
    // Status flags, enables and control
    // =========================================================================
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [15:0] status_set;
    logic [15:0] gp_r;
    logic [15:0] gp_nxt;
    logic [15:0] gp_set;
    logic [15:0] resume_en_r;
    logic [15:0] resume_en_nxt;
    logic [2:0]  kind_r;
    logic [2:0]  kind_nxt;
    logic [1:0]  ctrl_low_r;
    logic [1:0]  ctrl_low_nxt;
    logic        fw_flag_r;
    logic        fw_flag_nxt;
    logic        lid_prev_r;
    logic        rel_trigger;
    logic        resume_event;
    logic        sci_route_enable;

    always_comb begin
        sci_route_enable      = ctrl_low_r[`PM_BIT_SCI_ROUTE_ENABLE];
        rel_trigger = wr_control & io_wdata[`PM_BIT_REL_TRIG];
        status_set  = 16'h0000;
        status_set[`PM_BIT_ALARM]     = alarm_irq;
        status_set[`PM_BIT_BUTTON]    = btn_set;
        status_set[`PM_BIT_OVERRIDE]  = btn_override_hit;
        status_set[`PM_BIT_GLOBAL]    = firmware_release_bit;
        status_set[`PM_BIT_BUSMASTER] = bus_req;
        status_set[`PM_BIT_TMROF]     = tmr_toggle;
        gp_set = 16'h0000;
        gp_set[`PM_BIT_LID]     = lid_level & ~lid_prev_r;
        gp_set[`PM_BIT_GPI]     = general_input_event;
        gp_set[`PM_BIT_USB]     = usb_activity_event;
        gp_set[`PM_BIT_THERMAL] = thermal_event;
        resume_event = btn_set
                     | (status_set[`PM_BIT_ALARM] & resume_en_r[`PM_BIT_ALARM])
                     | (gp_set[`PM_BIT_LID] & lid_event_enable);
        status_set[`PM_BIT_RESUME] = resume_event;
        // Write-one clears first, then hardware sets so a coincident event survives.
        status_nxt = (status_r & ~(wr_status ? io_wdata[15:0] : 16'h0000)) | status_set;
        if (btn_override_hit) begin
            status_nxt[`PM_BIT_BUTTON] = 1'b0;
        end
        gp_nxt = (gp_r & ~(wr_gp ? io_wdata[15:0] : 16'h0000)) | gp_set;
        resume_en_nxt = resume_en_r;
        if (io_wr & sel_resume_en) begin
            resume_en_nxt = io_wdata[15:0] & 16'h0521;
        end
        kind_nxt     = kind_r;
        ctrl_low_nxt = ctrl_low_r;
        if (wr_control) begin
            kind_nxt     = io_wdata[`PM_KIND_HI:`PM_KIND_LO];
            ctrl_low_nxt = io_wdata[1:0];
        end
        fw_flag_nxt = (fw_flag_r & ~firmware_event_clear)
                    | (rel_trigger & firmware_event_enable);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status_r    <= `PM_RESET_VALUE;
            gp_r        <= `PM_RESET_VALUE;
            resume_en_r <= `PM_RESET_VALUE;
            kind_r      <= 3'h0;
            ctrl_low_r  <= 2'h0;
            fw_flag_r   <= 1'b0;
            // Lid counts as seen at reset, so with lid_polarity 1 a settled pin gives no false edge.
            lid_prev_r  <= 1'b1;
        end else begin
            status_r    <= status_nxt;
            gp_r        <= gp_nxt;
            resume_en_r <= resume_en_nxt;
            kind_r      <= kind_nxt;
            ctrl_low_r  <= ctrl_low_nxt;
            fw_flag_r   <= fw_flag_nxt;
            lid_prev_r  <= lid_level;
        end
    end

    // ====================
    // Interrupt routing, sequencing outputs and read data
    // =========================================================================
    logic        sci_nxt;
    logic        smi_nxt;
    logic        routed_btn;
    logic        routed_lid;
    logic [31:0] rdata_nxt;
    logic [15:0] ctrl_read;

    always_comb begin
        routed_btn = status_r[`PM_BIT_BUTTON] & resume_en_r[`PM_BIT_BUTTON];
        routed_lid = gp_r[`PM_BIT_LID] & lid_event_enable;
        sci_nxt = sci_route_enable & ((status_r[`PM_BIT_TMROF] & resume_en_r[`PM_BIT_TMROF])
                | (status_r[`PM_BIT_GLOBAL] & resume_en_r[`PM_BIT_GLOBAL])
                | gp_r[`PM_BIT_THERMAL] | gp_r[`PM_BIT_GPI] | gp_r[`PM_BIT_USB]
                | routed_btn | routed_lid);
        smi_nxt = fw_flag_r | (~sci_route_enable & (routed_btn | routed_lid));
        ctrl_read = 16'h0000;
        ctrl_read[`PM_KIND_HI:`PM_KIND_LO] = kind_r;
        ctrl_read[1:0] = ctrl_low_r;
        rdata_nxt = 32'h00000000;
        if (io_rd) begin
            if (sel_status) begin
                rdata_nxt = {16'h0000, status_r};
            end else if (sel_resume_en) begin
                rdata_nxt = {16'h0000, resume_en_r};
            end else if (sel_control) begin
                rdata_nxt = {16'h0000, ctrl_read};
            end else if (sel_timer) begin
                rdata_nxt = {8'h00, timer_count_r};
            end else if (sel_gp) begin
                rdata_nxt = {16'h0000, gp_r};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_rdata           <= 32'h00000000;
            sci_out            <= 1'b0;
            mgmt_interrupt_n   <= 1'b1;
            wake_to_on         <= 1'b0;
            power_off          <= 1'b0;
            suspend_start      <= 1'b0;
            burst_reload_event <= 1'b0;
        end else begin
            io_rdata           <= rdata_nxt;
            sci_out            <= sci_nxt;
            mgmt_interrupt_n   <= ~smi_nxt;
            wake_to_on         <= resume_event;
            power_off          <= btn_override_hit;
            suspend_start      <= wr_control & io_wdata[`PM_BIT_SUSP_TRIG];
            burst_reload_event <= bus_req & ctrl_low_r[`PM_BIT_BM_RELOAD];
        end
    end

    assign suspend_kind        = kind_r;
    assign firmware_event_flag = fw_flag_r;

endmodule // power_mgmt_event_status

`default_nettype wire

// file: pm_event_consts.svh
// Offsets, field positions, reset values, clock rates and times of the power management event block.
`ifndef PM_EVENT_CONSTS_SVH
`define PM_EVENT_CONSTS_SVH

`define PM_OFS_STATUS     16'h0000
`define PM_OFS_RESUME_EN  16'h0002
`define PM_OFS_CONTROL    16'h0004
`define PM_OFS_TIMER      16'h0008
`define PM_OFS_GP_STATUS  16'h000c
`define PM_BASE_MASK      16'hfffc
`define PM_RESET_VALUE    16'h0000

`define PM_BIT_RESUME     15
`define PM_BIT_OVERRIDE   11
`define PM_BIT_ALARM      10
`define PM_BIT_BUTTON     8
`define PM_BIT_GLOBAL     5
`define PM_BIT_BUSMASTER  4
`define PM_BIT_TMROF      0
`define PM_BIT_SUSP_TRIG  13
`define PM_KIND_HI        12
`define PM_KIND_LO        10
`define PM_BIT_REL_TRIG   2
`define PM_BIT_BM_RELOAD  1
`define PM_BIT_SCI_ROUTE_ENABLE     0
`define PM_BIT_LID        11
`define PM_BIT_GPI        9
`define PM_BIT_USB        8
`define PM_BIT_THERMAL    0
`define PM_TMR_MSB        23

`define PM_CLK_HZ         100000000
`define PM_TMR_HZ         3579545
`define PM_CLK_MHZ        100
`define PM_DEBOUNCE_MS    170
`define PM_OVERRIDE_S     4

`endif

// file: pm_event_pkg.sv
// Types shared by the power management event block.
package pm_event_pkg;

    typedef enum logic [2:0] {
        soft_off_or_disk      = 3'b000,
        suspend_to_memory     = 3'b001,
        powered_idle_lost     = 3'b010,
        powered_idle_cpu_lost = 3'b011,
        powered_idle_kept     = 3'b100,
        working               = 3'b101,
        kind_reserved_a       = 3'b110,
        kind_reserved_b       = 3'b111
    } suspend_kind_e;

    typedef enum logic [1:0] {
        btn_idle     = 2'b00,
        btn_debounce = 2'b01,
        btn_pressed  = 2'b10,
        btn_override = 2'b11
    } button_state_e;

endpackage

// file: pm_event_asserts.sv
// Concurrent assertions on the ports of the power management event block.
`timescale 1ns/100ps
`default_nettype none
`include "pm_event_consts.svh"
module pm_event_asserts (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [15:0] pm_base,
    input wire logic        pm_io_enable,
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [31:0] io_wdata,
    input wire logic [31:0] io_rdata,
    input wire logic        io_claim,
    input wire logic        override_enable,
    input wire logic        firmware_event_enable,
    input wire logic        firmware_event_clear,
    input wire logic        firmware_event_flag,
    input wire logic        sci_out,
    input wire logic        mgmt_interrupt_n,
    input wire logic        wake_to_on,
    input wire logic        power_off,
    input wire logic        suspend_start,
    input wire logic [2:0]  suspend_kind,
    input wire logic        burst_reload_event
);
    logic [15:0] base_w;
    logic        ctl_wr, ctl_rd, tmr_rd;
    logic        sci_route_enable_r, rel_en_r;

    assign base_w = pm_base & `PM_BASE_MASK;
    assign ctl_wr = io_wr && pm_io_enable && io_addr == base_w + `PM_OFS_CONTROL;
    assign ctl_rd = io_rd && pm_io_enable && io_addr == base_w + `PM_OFS_CONTROL;
    assign tmr_rd = io_rd && pm_io_enable && io_addr == base_w + `PM_OFS_TIMER;

    // ====================
    // Shadow copies of the control enables that gate SCI and reload.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sci_route_enable_r <= 1'b0;
            rel_en_r <= 1'b0;
        end else if (ctl_wr) begin
            sci_route_enable_r <= io_wdata[`PM_BIT_SCI_ROUTE_ENABLE];
            rel_en_r <= io_wdata[`PM_BIT_BM_RELOAD];
        end
    end

    // ====================
    // Properties.
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    claim_needs_en_a: assert property (io_claim |-> pm_io_enable && (io_wr || io_rd))
        else $error("stray claim");
    timer_claim_a: assert property (tmr_rd |-> io_claim)
        else $error("timer read unclaimed");
    idle_rdata_a: assert property (!(io_rd && io_claim) |=> io_rdata == 32'h0)
        else $error("read data not idle");
    susp_pulse_a: assert property (ctl_wr && io_wdata[13] |=> suspend_start ##1 !suspend_start)
        else $error("suspend start pulse wrong");
    kind_store_a: assert property (ctl_wr |=> suspend_kind == $past(io_wdata[12:10]))
        else $error("suspend kind not stored");
    ctl_read_zero_a: assert property (ctl_rd |=> !io_rdata[13] && !io_rdata[2])
        else $error("write-only bits read");
    smi_trigger_a: assert property (ctl_wr && io_wdata[2] && firmware_event_enable
        && !firmware_event_clear |-> ##2 !mgmt_interrupt_n && firmware_event_flag)
        else $error("trigger gave no interrupt");
    flag_smi_a: assert property (firmware_event_flag |=> !mgmt_interrupt_n)
        else $error("flag without interrupt");
    wake_pulse_a: assert property (wake_to_on |=> !wake_to_on)
        else $error("long wake pulse");
    off_needs_en_a: assert property (power_off |-> $past(override_enable) ##1 !power_off)
        else $error("off without enable");
    sci_gate_a: assert property (!sci_route_enable_r && !$past(sci_route_enable_r) |-> !sci_out)
        else $error("SCI while disabled");
    reload_gate_a: assert property (burst_reload_event |-> rel_en_r || $past(rel_en_r))
        else $error("reload while disabled");
endmodule // pm_event_asserts
`default_nettype wire

// file: pm_pins_model.sv
// Model of the button and bus request pins that face the block.
`timescale 1ns/100ps
`default_nettype none
module pm_pins_model (
    input  wire logic       clock,
    input  wire logic       press,
    input  wire logic [4:0] req,
    output var logic        power_button_n,
    output var logic  [3:0] pci_request_n,
    output var logic        pc_pci_hold_n
);
    always @(posedge clock) begin
        power_button_n <= !press;
        pci_request_n <= ~req[3:0];
        pc_pci_hold_n <= !req[4];
    end
endmodule // pm_pins_model
`default_nettype wire

// file: power_mgmt_event_status_tb.sv
// Self-checking testbench of the power management event block.
`timescale 1ns/100ps
`default_nettype none
`include "pm_event_consts.svh"
module power_mgmt_event_status_tb import pm_event_pkg::*;;
    localparam logic [15:0] base_addr = 16'h4000;
    logic clock = 1'b0, sys_rst = 1'b1, pm_io_enable = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] pm_base = 16'h4003, io_addr = 16'h0;
    logic [31:0] io_wdata = 32'h0, io_rdata, rd, t0;
    logic io_claim, claim, power_button_n, pc_pci_hold_n, press = 1'b0;
    logic [3:0] pci_request_n;
    logic [4:0] req = 5'h0;
    logic lid_in = 1'b0, osc_running = 1'b0, alarm_irq = 1'b0, alarm_with_wr = 1'b0;
    logic thermal_event = 1'b0, general_input_event = 1'b0, usb_activity_event = 1'b0;
    logic override_enable = 1'b0, lid_polarity = 1'b1, lid_event_enable = 1'b0;
    logic firmware_release_bit = 1'b0, firmware_event_enable = 1'b0;
    logic firmware_event_clear = 1'b0, firmware_event_flag, sci_out, mgmt_interrupt_n;
    logic wake_to_on, power_off, suspend_start, burst_reload_event;
    logic [2:0] suspend_kind;
    logic [15:0] gp_bit [3] = '{16'h0001, 16'h0200, 16'h0100};
    int error_cnt = 0, checked = 0, wake_cnt = 0, off_cnt = 0, rel_cnt = 0;

    power_mgmt_event_status #(.DEBOUNCE_CYCLES(20), .OVERRIDE_CYCLES(60)) dut_u (
        .clock, .sys_rst, .pm_base, .pm_io_enable, .io_addr, .io_wr, .io_rd, .io_wdata,
        .io_rdata, .io_claim, .power_button_n, .pci_request_n, .pc_pci_hold_n, .lid_in,
        .osc_running, .alarm_irq, .thermal_event, .general_input_event, .usb_activity_event,
        .override_enable, .lid_polarity, .lid_event_enable, .firmware_release_bit,
        .firmware_event_enable, .firmware_event_clear, .firmware_event_flag, .sci_out,
        .mgmt_interrupt_n, .wake_to_on, .power_off, .suspend_start, .suspend_kind,
        .burst_reload_event);
    pm_pins_model pins_u (.clock, .press, .req, .power_button_n, .pci_request_n,
        .pc_pci_hold_n);

    always #5 clock = ~clock;
    always @(posedge clock) begin
        if (wake_to_on === 1'b1) wake_cnt++;
        if (power_off === 1'b1) off_cnt++;
        if (burst_reload_event === 1'b1) rel_cnt++;
    end

    // ====================
    // Access and comparison tasks.
    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check1(input string name, input logic exp, input logic got);
        check32(name, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic io_write(input logic [15:0] ofs, input logic [31:0] d);
        @(negedge clock);
        io_addr = base_addr + ofs;
        io_wdata = d;
        io_wr = 1'b1;
        alarm_irq = alarm_with_wr;
        @(negedge clock);
        io_wr = 1'b0;
        alarm_irq = 1'b0;
    endtask
    task automatic io_read(input logic [15:0] ofs, output logic [31:0] d);
        @(negedge clock);
        io_addr = base_addr + ofs;
        io_rd = 1'b1;
        #1 claim = io_claim;
        @(negedge clock);
        io_rd = 1'b0;
        d = io_rdata;
    endtask
    task automatic rchk(input string name, input logic [15:0] ofs, input logic [31:0] exp);
        logic [31:0] v;
        io_read(ofs, v);
        check1("claim", 1'b1, claim);
        check32(name, exp, v);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ====================
    // Test sequence.
    initial begin
        wait_cyc(16);
        sys_rst = 1'b0;
        rchk("timer", `PM_OFS_TIMER, 32'h0);
        rchk("status", `PM_OFS_STATUS, 32'h0);
        rchk("resume_en", `PM_OFS_RESUME_EN, 32'h0);
        rchk("control", `PM_OFS_CONTROL, 32'h0);
        rchk("gp_status", `PM_OFS_GP_STATUS, 32'h0);
        io_read(16'h0006, rd);
        check1("gap_claim", 1'b0, claim);
        check32("gap_data", 32'h0, rd);
        pm_io_enable = 1'b0;
        io_write(`PM_OFS_RESUME_EN, 32'hffff);
        io_read(`PM_OFS_STATUS, rd);
        check1("off_claim", 1'b0, claim);
        pm_io_enable = 1'b1;
        rchk("resume_en", `PM_OFS_RESUME_EN, 32'h0);
        io_write(`PM_OFS_RESUME_EN, 32'hffff);
        rchk("resume_en", `PM_OFS_RESUME_EN, 32'h0521);
        io_write(`PM_OFS_RESUME_EN, 32'h0);
        osc_running = 1'b1;
        wait_cyc(400);
        io_read(`PM_OFS_TIMER, rd);
        check1("timer_runs", 1'b1, rd >= 12 && rd <= 16);
        osc_running = 1'b0;
        wait_cyc(5);
        io_read(`PM_OFS_TIMER, t0);
        wait_cyc(100);
        rchk("timer_held", `PM_OFS_TIMER, t0);
        osc_running = 1'b1;
        wait_cyc(60);
        io_read(`PM_OFS_TIMER, rd);
        check1("timer_resumes", 1'b1, rd > t0 && rd < t0 + 5);
        for (int k = 0; k < 8; k++) begin
            io_write(`PM_OFS_CONTROL, 32'h2000 | (32'(k) << 10));
            check1("suspend_start", 1'b1, suspend_start);
            check32("suspend_kind", 32'(k), {29'h0, suspend_kind});
            rchk("control", `PM_OFS_CONTROL, 32'(k) << 10);
        end
        io_write(`PM_OFS_CONTROL, 32'(working) << 10);
        check1("no_start", 1'b0, suspend_start);
        alarm_irq = 1'b1;
        wait_cyc(1);
        alarm_irq = 1'b0;
        rchk("alarm", `PM_OFS_STATUS, 32'h0400);
        io_write(`PM_OFS_STATUS, 32'h0);
        rchk("alarm_kept", `PM_OFS_STATUS, 32'h0400);
        alarm_with_wr = 1'b1;
        io_write(`PM_OFS_STATUS, 32'h0400);
        alarm_with_wr = 1'b0;
        rchk("set_wins", `PM_OFS_STATUS, 32'h0400);
        io_write(`PM_OFS_STATUS, 32'h0400);
        rchk("cleared", `PM_OFS_STATUS, 32'h0);
        io_write(`PM_OFS_RESUME_EN, 32'h0400);
        alarm_irq = 1'b1;
        wait_cyc(1);
        alarm_irq = 1'b0;
        rchk("alarm_resume", `PM_OFS_STATUS, 32'h8400);
        check32("wakes", 32'd1, wake_cnt);
        io_write(`PM_OFS_STATUS, 32'h8400);
        io_write(`PM_OFS_CONTROL, 32'h2);
        for (int k = 0; k < 5; k++) begin
            req = 5'(1 << k);
            wait_cyc(6);
            req = 5'h0;
            rchk("bus_master", `PM_OFS_STATUS, 32'h0010);
            io_write(`PM_OFS_STATUS, 32'h0010);
        end
        check1("reload", 1'b1, rel_cnt >= 5);
        io_write(`PM_OFS_CONTROL, 32'h0);
        io_write(`PM_OFS_RESUME_EN, 32'h0100);
        press = 1'b1;
        wait_cyc(10);
        press = 1'b0;
        wait_cyc(5);
        rchk("short_press", `PM_OFS_STATUS, 32'h0);
        press = 1'b1;
        wait_cyc(40);
        check1("button_smi", 1'b0, mgmt_interrupt_n);
        press = 1'b0;
        rchk("button", `PM_OFS_STATUS, 32'h8100);
        check32("wakes", 32'd2, wake_cnt);
        io_write(`PM_OFS_STATUS, 32'h8100);
        wait_cyc(3);
        check1("smi_idle", 1'b1, mgmt_interrupt_n);
        override_enable = 1'b1;
        press = 1'b1;
        wait_cyc(90);
        press = 1'b0;
        rchk("override", `PM_OFS_STATUS, 32'h8800);
        check32("power_off", 32'd1, off_cnt);
        io_write(`PM_OFS_STATUS, 32'h8800);
        override_enable = 1'b0;
        io_write(`PM_OFS_RESUME_EN, 32'h0020);
        io_write(`PM_OFS_CONTROL, 32'h1);
        for (int e = 1; e >= 0; e--) begin
            firmware_release_bit = 1'b1;
            wait_cyc(1);
            firmware_release_bit = 1'b0;
            wait_cyc(3);
            check1("sci_release", e[0], sci_out);
            rchk("global", `PM_OFS_STATUS, 32'h0020);
            io_write(`PM_OFS_STATUS, 32'h0020);
            io_write(`PM_OFS_RESUME_EN, 32'h0);
        end
        for (int k = 0; k < 3; k++) begin
            {usb_activity_event, general_input_event, thermal_event} = 3'(1 << k);
            wait_cyc(1);
            {usb_activity_event, general_input_event, thermal_event} = 3'h0;
            wait_cyc(3);
            check1("sci_gp", 1'b1, sci_out);
            rchk("gp_status", `PM_OFS_GP_STATUS, {16'h0, gp_bit[k]});
            io_write(`PM_OFS_GP_STATUS, {16'h0, gp_bit[k]});
        end
        lid_event_enable = 1'b1;
        for (int p = 0; p < 2; p++) begin
            lid_polarity = p[0];
            lid_in = !p[0];
            wait_cyc(5);
            io_write(`PM_OFS_GP_STATUS, 32'h0800);
            lid_in = p[0];
            wait_cyc(6);
            check1("sci_lid", 1'b1, sci_out);
            rchk("lid", `PM_OFS_GP_STATUS, 32'h0800);
        end
        io_write(`PM_OFS_GP_STATUS, 32'h0800);
        io_write(`PM_OFS_STATUS, 32'h8000);
        lid_event_enable = 1'b0;
        io_write(`PM_OFS_CONTROL, 32'h0);
        firmware_event_enable = 1'b1;
        io_write(`PM_OFS_CONTROL, 32'h4);
        wait_cyc(2);
        check1("fw_flag", 1'b1, firmware_event_flag);
        check1("fw_smi", 1'b0, mgmt_interrupt_n);
        firmware_event_clear = 1'b1;
        wait_cyc(1);
        firmware_event_clear = 1'b0;
        firmware_event_enable = 1'b0;
        io_write(`PM_OFS_CONTROL, 32'h4);
        wait_cyc(2);
        check1("fw_gated", 1'b0, firmware_event_flag);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end
endmodule // power_mgmt_event_status_tb

bind power_mgmt_event_status pm_event_asserts chk_u (.clock, .sys_rst, .pm_base,
    .pm_io_enable, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .io_claim, .override_enable, .firmware_event_enable, .firmware_event_clear,
    .firmware_event_flag, .sci_out, .mgmt_interrupt_n, .wake_to_on, .power_off,
    .suspend_start, .suspend_kind, .burst_reload_event);
`default_nettype wire
